/* File: inc/pis_pkg.sv */
// Purpose: Shared constants for the packet interval scheduler device block
// Assumes: One link cycle per enabled clk_sys cycle
// Notes: Register map is word aligned on a 32-bit Avalon-MM slave
package pis_pkg;
    // Geometry
    localparam int NBANK = 32;
    localparam int BANK_W = 5;
    localparam int LAT_W = 4;
    localparam int LANE_W = 64;
    localparam int MASK_W = 8;
    localparam int PKT_BYTES = 16;
    // Latency limits and reset values, in link cycles
    localparam logic [LAT_W-1:0] RL_MIN = 4'h7;
    localparam logic [LAT_W-1:0] RL_MAX = 4'hC;
    localparam logic [LAT_W-1:0] RL_RST = 4'h8;
    localparam logic [LAT_W-1:0] WL_MIN = 4'h1;
    localparam logic [LAT_W-1:0] WL_RST = 4'h6;
    localparam int RETIRE_DEF = 8;
    localparam int PIPE_DEPTH = 12;
    // Register byte offsets
    localparam logic [3:0] REG_LAT = 4'h0;
    localparam logic [3:0] REG_BANKS = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    // Field positions
    localparam int F_RL_LO = 0;
    localparam int F_WL_LO = 8;
    localparam int F_ILLEGAL_ACT = 0;
    localparam int F_WR_OVERRUN = 1;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

/* File: src/pis_lat_pipe.sv */
// Purpose: Delay line that presents a pushed payload a chosen number of cycles later
// Assumes: lat in 1..DEPTH; larger values never produce a tap
// Notes: Payload enters stage 0 at the edge that takes the push
`timescale 1ns/1ps
module pis_lat_pipe #(
    parameter int W = 8,
    parameter int DEPTH = 12
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    // Push side
    input wire logic push_valid,
    input wire logic [W-1:0] push_data,
    // Tap select and output
    input wire logic [pis_pkg::LAT_W-1:0] lat,
    output logic tap_valid,
    output logic [W-1:0] tap_data
);
    import pis_pkg::*;

    logic [DEPTH-1:0] vld_ff, nxt_vld;
    logic [W-1:0] dat_ff [DEPTH];
    logic [W-1:0] nxt_dat [DEPTH];

    // Shift by one stage per enabled cycle
    always_comb begin
        nxt_vld = vld_ff;
        nxt_dat = dat_ff;
        if (ce) begin
            nxt_vld = {vld_ff[DEPTH-2:0], push_valid};
            nxt_dat[0] = push_data;
            for (int i = 1; i < DEPTH; i++) begin
                nxt_dat[i] = dat_ff[i-1];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            vld_ff <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                dat_ff[i] <= '0;
            end
        end else begin
            vld_ff <= nxt_vld;
            dat_ff <= nxt_dat;
        end
    end

    // Stage lat-1 holds what was pushed lat cycles before this cycle
    always_comb begin
        tap_valid = 1'b0;
        tap_data = '0;
        for (int i = 0; i < DEPTH; i++) begin
            if (32'(lat) == i + 1) begin
                tap_valid = vld_ff[i];
                tap_data = dat_ff[i];
            end
        end
    end
endmodule // pis_lat_pipe

/* File: src/pis_core.sv */
// Purpose: Device side data timing, byte masking and bank state of a packet DRAM channel
// Assumes: Column, slot and row packets arrive as one-cycle strobes at their trailing edge
`timescale 1ns/1ps
module pis_core #(
    parameter int RETIRE_INTERVAL = pis_pkg::RETIRE_DEF
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    // Avalon-MM register slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Column command packet
    input wire logic col_valid,
    input wire logic col_read,
    input wire logic col_write,
    input wire logic col_autopre,
    input wire logic [pis_pkg::BANK_W-1:0] col_bank,
    // Slot after a column command: mask or extended packet
    input wire logic slot_valid,
    input wire logic slot_mask_sel,
    input wire logic [pis_pkg::MASK_W-1:0] mask_field_low,
    input wire logic [pis_pkg::MASK_W-1:0] mask_field_high,
    input wire logic slot_extended_precharge,
    input wire logic [pis_pkg::BANK_W-1:0] slot_bank,
    // Row packets
    input wire logic row_activate,
    input wire logic row_bus_precharge,
    input wire logic [pis_pkg::BANK_W-1:0] row_bank,
    // Write data packet from the channel
    input wire logic [pis_pkg::LANE_W-1:0] wd_lane_a,
    input wire logic [pis_pkg::LANE_W-1:0] wd_lane_b,
    // Read data from the array, driven out as a packet
    input wire logic [pis_pkg::LANE_W-1:0] arr_rd_lane_a,
    input wire logic [pis_pkg::LANE_W-1:0] arr_rd_lane_b,
    output logic rd_pkt_valid,
    output logic [pis_pkg::LANE_W-1:0] data_byte_lane_a,
    output logic [pis_pkg::LANE_W-1:0] data_byte_lane_b,
    output logic [pis_pkg::BANK_W-1:0] arr_rd_bank,
    // Array write port
    output logic arr_wr_en,
    output logic [pis_pkg::BANK_W-1:0] arr_wr_bank,
    output logic [pis_pkg::LANE_W-1:0] arr_wr_lane_a,
    output logic [pis_pkg::LANE_W-1:0] arr_wr_lane_b,
    output logic [pis_pkg::PKT_BYTES-1:0] arr_wr_byte_en
);
    import pis_pkg::*;

    // Bank bit plus its two neighbours, clipped at the ends
    function automatic logic [NBANK-1:0] near_mask(input logic [BANK_W-1:0] b);
        logic [NBANK-1:0] m;
        m = '0;
        m[b] = 1'b1;
        if (b != '0) m[b - 1'b1] = 1'b1;
        if (b != BANK_W'(NBANK - 1)) m[b + 1'b1] = 1'b1;
        return m;
    endfunction

    // Register state
    logic [LAT_W-1:0] rl_ff, nxt_rl, wl_ff, nxt_wl;
    logic [NBANK-1:0] act_ff, nxt_act;
    logic illegal_ff, nxt_illegal, overrun_ff, nxt_overrun;
    logic wait_ff, nxt_wait;
    logic [31:0] rdata_ff, nxt_rdata;
    // Pending write state
    logic wd_have_ff, nxt_wd_have, mk_have_ff, nxt_mk_have;
    logic [LANE_W-1:0] wa_ff, nxt_wa, wb_ff, nxt_wb;
    logic [PKT_BYTES-1:0] be_ff, nxt_be;
    logic [BANK_W:0] wbank_ff, nxt_wbank;
    // Output state
    logic rdv_ff, nxt_rdv, awe_ff, nxt_awe;
    logic [LANE_W-1:0] rda_ff, nxt_rda, rdb_ff, nxt_rdb;
    logic [BANK_W-1:0] rbank_ff, nxt_rbank, awb_ff, nxt_awb;
    logic [LANE_W-1:0] awa_ff, nxt_awa, awbd_ff, nxt_awbd;
    logic [PKT_BYTES-1:0] awbe_ff, nxt_awbe;

    logic rd_tap, wd_tap, mk_tap;
    logic [BANK_W-1:0] rd_tap_bank;
    logic [BANK_W:0] wd_tap_info, mk_tap_info;
    logic bus_go, bus_wr;
    logic [LAT_W-1:0] new_rl, new_wl;
    logic [NBANK-1:0] pre_set;
    logic commit;
    localparam logic [LAT_W-1:0] RETIRE_LAT = LAT_W'(RETIRE_INTERVAL);

    // Read data timing: tap one cycle early, the output flop supplies the last cycle of read latency
    pis_lat_pipe #(.W(BANK_W), .DEPTH(PIPE_DEPTH)) u_rd_pipe (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce),
        .push_valid(col_valid & col_read), .push_data(col_bank),
        .lat(rl_ff - 4'h1), .tap_valid(rd_tap), .tap_data(rd_tap_bank)
    );
    // Write data timing: tap at the write latency, carries autoprecharge flag
    pis_lat_pipe #(.W(BANK_W + 1), .DEPTH(PIPE_DEPTH)) u_wd_pipe (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce),
        .push_valid(col_valid & col_write), .push_data({col_autopre, col_bank}),
        .lat(wl_ff), .tap_valid(wd_tap), .tap_data(wd_tap_info)
    );
    // Mask slot timing: fixed retire interval after the write command
    pis_lat_pipe #(.W(BANK_W + 1), .DEPTH(PIPE_DEPTH)) u_mk_pipe (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce),
        .push_valid(col_valid & col_write), .push_data({col_autopre, col_bank}),
        .lat(RETIRE_LAT), .tap_valid(mk_tap), .tap_data(mk_tap_info)
    );

    // Bus decode: a request is served at the edge where waitrequest is low
    always_comb begin
        bus_go = (avs_read | avs_write) & ~wait_ff;
        bus_wr = bus_go & avs_write;
        new_rl = avs_writedata[F_RL_LO +: LAT_W];
        new_wl = avs_writedata[F_WL_LO +: LAT_W];
    end

    // Registers and bus answer
    always_comb begin
        nxt_rl = rl_ff;
        nxt_wl = wl_ff;
        nxt_wait = ~((avs_read | avs_write) & wait_ff);
        nxt_rdata = rdata_ff;
        if ((avs_read | avs_write) & wait_ff) begin
            case (avs_address)
                REG_LAT: nxt_rdata = {20'h0_0000, wl_ff, 4'h0, rl_ff};
                REG_BANKS: nxt_rdata = act_ff;
                REG_STATUS: nxt_rdata = {30'h0000_0000, overrun_ff, illegal_ff};
                default: nxt_rdata = RD_ZERO;
            endcase
        end
        // Only legal pairs are taken, so write latency stays below read latency
        if (bus_wr && avs_address == REG_LAT && avs_byteenable[0] && avs_byteenable[1] &&
            new_rl >= RL_MIN && new_rl <= RL_MAX && new_wl >= WL_MIN && new_wl < new_rl) begin
            nxt_rl = new_rl;
            nxt_wl = new_wl;
        end
    end

    // Bank state, pending write and outputs
    always_comb begin
        nxt_act = act_ff;
        nxt_illegal = illegal_ff;
        nxt_overrun = overrun_ff;
        nxt_wd_have = wd_have_ff;
        nxt_mk_have = mk_have_ff;
        nxt_wa = wa_ff;
        nxt_wb = wb_ff;
        nxt_be = be_ff;
        nxt_wbank = wbank_ff;
        nxt_rdv = 1'b0;
        nxt_rda = rda_ff;
        nxt_rdb = rdb_ff;
        nxt_rbank = rbank_ff;
        nxt_awe = 1'b0;
        nxt_awb = awb_ff;
        nxt_awa = awa_ff;
        nxt_awbd = awbd_ff;
        nxt_awbe = awbe_ff;
        pre_set = '0;
        commit = 1'b0;
        // Status clears by writing one; applied first so an event later in this cycle sets it again
        if (bus_wr && avs_address == REG_STATUS && avs_byteenable[0]) begin
            if (avs_writedata[F_ILLEGAL_ACT]) nxt_illegal = 1'b0;
            if (avs_writedata[F_WR_OVERRUN]) nxt_overrun = 1'b0;
        end
        // Read packet leaves at the data packet's leading edge
        if (rd_tap) begin
            nxt_rdv = 1'b1;
            nxt_rda = arr_rd_lane_a;
            nxt_rdb = arr_rd_lane_b;
            nxt_rbank = rd_tap_bank;
        end
        // A read with autoprecharge closes its bank; reads take no mask slot
        if (col_valid && col_read && col_autopre) begin
            pre_set = pre_set | near_mask(col_bank);
        end
        // Capture the write data packet
        if (wd_tap) begin
            if (wd_have_ff) nxt_overrun = 1'b1;
            nxt_wd_have = 1'b1;
            nxt_wa = wd_lane_a;
            nxt_wb = wd_lane_b;
            nxt_wbank = wd_tap_info;
        end
        // Mask slot: set select carries two mask fields, clear writes every byte
        if (mk_tap) begin
            nxt_mk_have = 1'b1;
            if (slot_valid && slot_mask_sel) begin
                nxt_be = {mask_field_high, mask_field_low};
            end else begin
                nxt_be = '1;
            end
        end
        // Extended precharge rides in any slot whose select bit is clear
        if (slot_valid && !slot_mask_sel && slot_extended_precharge) begin
            pre_set = pre_set | near_mask(slot_bank);
        end
        // Retire the write once data and mask are both in hand
        if (nxt_wd_have && nxt_mk_have) begin
            commit = 1'b1;
            nxt_wd_have = 1'b0;
            nxt_mk_have = 1'b0;
            nxt_awe = 1'b1;
            nxt_awb = nxt_wbank[BANK_W-1:0];
            nxt_awa = nxt_wa;
            nxt_awbd = nxt_wb;
            nxt_awbe = nxt_be;
        end
        // Write with autoprecharge closes the bank in the same cycle as the retire
        if (commit && nxt_wbank[BANK_W]) begin
            pre_set = pre_set | near_mask(nxt_wbank[BANK_W-1:0]);
        end
        if (row_bus_precharge) begin
            pre_set = pre_set | near_mask(row_bank);
        end
        // Precharge closes the bank and whichever neighbour is active
        nxt_act = nxt_act & ~pre_set;
        if (row_activate) begin
            // Opening next to an open bank would share a sense amp
            if ((nxt_act & near_mask(row_bank)) != '0) nxt_illegal = 1'b1;
            nxt_act = nxt_act & ~near_mask(row_bank);
            nxt_act[row_bank] = 1'b1;
        end
    end

    // Every state element holds while the clock enable is low
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rl_ff <= RL_RST;
            wl_ff <= WL_RST;
            wait_ff <= 1'b1;
            rdata_ff <= RD_ZERO;
            act_ff <= '0;
            illegal_ff <= 1'b0;
            overrun_ff <= 1'b0;
            wd_have_ff <= 1'b0;
            mk_have_ff <= 1'b0;
            wa_ff <= '0;
            wb_ff <= '0;
            be_ff <= '0;
            wbank_ff <= '0;
            rdv_ff <= 1'b0;
            rda_ff <= '0;
            rdb_ff <= '0;
            rbank_ff <= '0;
            awe_ff <= 1'b0;
            awb_ff <= '0;
            awa_ff <= '0;
            awbd_ff <= '0;
            awbe_ff <= '0;
        end else if (ce) begin
            rl_ff <= nxt_rl;
            wl_ff <= nxt_wl;
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
            act_ff <= nxt_act;
            illegal_ff <= nxt_illegal;
            overrun_ff <= nxt_overrun;
            wd_have_ff <= nxt_wd_have;
            mk_have_ff <= nxt_mk_have;
            wa_ff <= nxt_wa;
            wb_ff <= nxt_wb;
            be_ff <= nxt_be;
            wbank_ff <= nxt_wbank;
            rdv_ff <= nxt_rdv;
            rda_ff <= nxt_rda;
            rdb_ff <= nxt_rdb;
            rbank_ff <= nxt_rbank;
            awe_ff <= nxt_awe;
            awb_ff <= nxt_awb;
            awa_ff <= nxt_awa;
            awbd_ff <= nxt_awbd;
            awbe_ff <= nxt_awbe;
        end
    end

    // Outputs straight from flops
    assign avs_waitrequest = wait_ff;
    assign avs_readdata = rdata_ff;
    assign rd_pkt_valid = rdv_ff;
    assign data_byte_lane_a = rda_ff;
    assign data_byte_lane_b = rdb_ff;
    assign arr_rd_bank = rbank_ff;
    assign arr_wr_en = awe_ff;
    assign arr_wr_bank = awb_ff;
    assign arr_wr_lane_a = awa_ff;
    assign arr_wr_lane_b = awbd_ff;
    assign arr_wr_byte_en = awbe_ff;
endmodule // pis_core

/* File: tb/pis_checker_assertions.sv */
// Purpose: Port timing checks for the packet interval scheduler core
// Assumes: ce stays high; latencies are mirrored from accepted bus writes
// Notes: History bit k holds a command seen k+1 cycles ago
`timescale 1ns/1ps
module pis_checker #(
    parameter int RETIRE_INTERVAL = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Register bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    // Column, slot and data
    input wire logic col_valid,
    input wire logic col_read,
    input wire logic col_write,
    input wire logic slot_valid,
    input wire logic slot_mask_sel,
    input wire logic [7:0] mask_field_low,
    input wire logic [7:0] mask_field_high,
    input wire logic [63:0] arr_rd_lane_a,
    input wire logic rd_pkt_valid,
    input wire logic [63:0] data_byte_lane_a,
    input wire logic arr_wr_en,
    input wire logic [15:0] arr_wr_byte_en
);
    import pis_pkg::*;
    logic [3:0] rl_ff;
    logic [3:0] wl_ff;
    logic [15:0] rh_ff;
    logic [15:0] wh_ff;
    logic lat_ok;
    int wmax;
    // A refused latency write must not move the mirror
    assign lat_ok = avs_write && !avs_waitrequest && avs_address == REG_LAT && avs_byteenable[1:0] == 2'b11
        && avs_writedata[3:0] >= RL_MIN && avs_writedata[3:0] <= RL_MAX && avs_writedata[11:8] >= WL_MIN
        && avs_writedata[11:8] < avs_writedata[3:0];
    assign wmax = (int'(wl_ff) > RETIRE_INTERVAL) ? int'(wl_ff) : RETIRE_INTERVAL;
    // Latency mirror and command histories
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rl_ff <= RL_RST;
            wl_ff <= WL_RST;
            rh_ff <= '0;
            wh_ff <= '0;
        end else begin
            if (lat_ok) begin
                rl_ff <= avs_writedata[3:0];
                wl_ff <= avs_writedata[11:8];
            end
            rh_ff <= {rh_ff[14:0], col_valid & col_read};
            wh_ff <= {wh_ff[14:0], col_valid & col_write};
        end
    end
    rd_latency_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        rd_pkt_valid == rh_ff[rl_ff - 4'h1]) else $error("read packet out of place");
    rd_data_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        rd_pkt_valid |-> data_byte_lane_a == $past(arr_rd_lane_a)) else $error("read data not from array");
    wr_retire_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        arr_wr_en == wh_ff[wmax]) else $error("array write out of place");
    byte_mask_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        arr_wr_en && $past(slot_valid) |-> arr_wr_byte_en ==
        ($past(slot_mask_sel) ? {$past(mask_field_high), $past(mask_field_low)} : 16'hFFFF))
        else $error("byte enables wrong");
    wr_single_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        arr_wr_en |=> !arr_wr_en) else $error("array write held");
    bus_wait_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("bus answer late");
    bus_pulse_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(avs_waitrequest) |=> $rose(avs_waitrequest)) else $error("bus answer held");
    bus_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(avs_read || avs_write) |=> avs_waitrequest) else $error("bus answer without request");
endmodule // pis_checker

/* File: tb/pis_ctrl_model.sv */
// Purpose: Controller model driving column, slot and write data packets
// Assumes: One command at a time; the bench holds the go_ fields until the next go
// Notes: Idle data pins carry a changing pattern, never the last packet
`timescale 1ns/1ps
module pis_ctrl_model #(
    parameter int RET = 8
) (
    // Clock, reset and bench requests
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic go,
    input wire logic go_wr,
    input wire logic go_msk,
    input wire logic go_xpre,
    input wire logic go_ap,
    input wire logic [4:0] go_bank,
    input wire logic [15:0] go_mask,
    input wire logic [127:0] go_data,
    input wire logic [3:0] wl,
    // Column and slot packets
    output logic col_valid,
    output logic col_read,
    output logic col_write,
    output logic col_autopre,
    output logic [4:0] col_bank,
    output logic slot_valid,
    output logic slot_mask_sel,
    output logic [7:0] mask_field_low,
    output logic [7:0] mask_field_high,
    output logic slot_extended_precharge,
    output logic [4:0] slot_bank,
    // Write data packet
    output logic [63:0] wd_lane_a,
    output logic [63:0] wd_lane_b
);
    int cnt_ff;
    logic wr_ff;
    // Cycles since the last column packet; data and slot times hang off it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= 100;
            wr_ff <= 1'b0;
        end else if (go) begin
            cnt_ff <= 1;
            wr_ff <= go_wr;
        end else begin
            cnt_ff <= cnt_ff + 1;
        end
    end
    // One command in flight, so a write never crowds a read's data
    assign col_valid = go;
    assign col_read = go & ~go_wr;
    assign col_write = go & go_wr;
    assign col_autopre = go & go_ap;
    assign col_bank = go_bank;
    // Slot one retire interval on; a mask only ever follows a write
    assign slot_valid = (cnt_ff == RET);
    assign slot_mask_sel = wr_ff & go_msk;
    assign {mask_field_high, mask_field_low} = slot_valid ? go_mask : ~go_mask;
    assign slot_extended_precharge = slot_valid & ~slot_mask_sel & go_xpre;
    assign slot_bank = go_bank;
    assign {wd_lane_a, wd_lane_b} = (wr_ff && cnt_ff == int'(wl)) ? go_data : ~go_data ^ 128'(cnt_ff);
endmodule // pis_ctrl_model

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the packet interval scheduler core
// Assumes: ce held high; the controller model runs one command at a time
// Notes: Outputs are read right after a rising edge, before that edge lands
`timescale 1ns/1ps
module tb;
    import pis_pkg::*;
    localparam int RET = 8;
    // Quiet cycles after each row packet, wider than any row interval the controller must keep
    localparam int ROW_GAP = 10;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, col_valid, col_read, col_write, col_autopre, slot_valid, slot_mask_sel;
    logic slot_extended_precharge, rd_pkt_valid, arr_wr_en;
    logic [4:0] col_bank, slot_bank, arr_rd_bank, arr_wr_bank;
    logic [7:0] mask_field_low, mask_field_high;
    logic [63:0] wd_lane_a, wd_lane_b, arr_rd_lane_b, data_byte_lane_a, data_byte_lane_b, arr_wr_lane_a;
    logic [63:0] arr_wr_lane_b;
    logic [63:0] arr_rd_lane_a = 64'h0;
    logic [15:0] arr_wr_byte_en;
    logic row_activate = 1'b0;
    logic row_bus_precharge = 1'b0;
    logic [4:0] row_bank = 5'h00;
    logic go = 1'b0;
    logic go_wr = 1'b0;
    logic go_msk = 1'b0;
    logic go_xpre = 1'b0;
    logic go_ap = 1'b0;
    logic [4:0] go_bank = 5'h00;
    logic [15:0] go_mask = 16'h0000;
    logic [127:0] go_data = 128'h0;
    logic [3:0] wl = 4'h6;
    int failures = 0;
    int n_compared = 0;
    always #50 clk_sys = ~clk_sys;
    // Array data moves every cycle so an early or late sample shows
    always @(posedge clk_sys) arr_rd_lane_a <= arr_rd_lane_a + 64'h1;
    assign arr_rd_lane_b = ~arr_rd_lane_a;
    pis_core #(.RETIRE_INTERVAL(RET)) u_dut (.*);
    pis_ctrl_model #(.RET(RET)) u_ctrl (.*);
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pkt(input logic [127:0] got, input logic [127:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            failures++;
            report_and_stop();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk_reg(q, e);
    endtask
    task automatic row(input logic a, input logic [4:0] b);
        @(posedge clk_sys);
        row_activate <= a;
        row_bus_precharge <= !a;
        row_bank <= b;
        @(posedge clk_sys);
        row_activate <= 1'b0;
        row_bus_precharge <= 1'b0;
        repeat (ROW_GAP) @(posedge clk_sys);
    endtask
    // One column command; waits for its packet and checks cycle count and contents
    task automatic cmd(input logic w, input logic m, input logic x, input logic [4:0] b, input logic [15:0] k,
        input int lat);
        logic [63:0] prv;
        int n;
        @(posedge clk_sys);
        go <= 1'b1;
        go_wr <= w;
        go_msk <= m;
        go_xpre <= x;
        go_bank <= b;
        go_mask <= k;
        go_data <= {arr_rd_lane_a, ~arr_rd_lane_a} ^ {8{k}};
        @(posedge clk_sys);
        go <= 1'b0;
        prv = arr_rd_lane_a;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
            if ((w ? arr_wr_en : rd_pkt_valid) !== 1'b1) prv = arr_rd_lane_a;
        end while ((w ? arr_wr_en : rd_pkt_valid) !== 1'b1 && n < 40);
        if (n >= 40) begin
            failures++;
            report_and_stop();
        end
        chk_reg(32'(n), 32'(lat));
        if (w) begin
            chk_pkt({arr_wr_lane_a, arr_wr_lane_b}, go_data);
            chk_reg(32'({arr_wr_bank, arr_wr_byte_en}), 32'({b, m ? k : 16'hFFFF}));
        end else begin
            chk_pkt({data_byte_lane_a, data_byte_lane_b}, {prv, ~prv});
            chk_reg(32'(arr_rd_bank), 32'(b));
        end
    endtask
    initial begin
        logic [31:0] bad[4];
        bad = '{32'h0000_0206, 32'h0000_020D, 32'h0000_0808, 32'h0000_0009};
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        rd_chk(REG_LAT, 32'h0000_0608);
        rd_chk(REG_BANKS, 32'h0000_0000);
        rd_chk(REG_STATUS, 32'h0000_0000);
        bus(1'b1, 4'hC, 32'hFFFF_FFFF);
        rd_chk(4'hC, 32'h0000_0000);
        foreach (bad[i]) begin
            bus(1'b1, REG_LAT, bad[i]);
            rd_chk(REG_LAT, 32'h0000_0608);
        end
        avs_byteenable <= 4'h1;
        bus(1'b1, REG_LAT, 32'h0000_0207);
        avs_byteenable <= 4'hF;
        rd_chk(REG_LAT, 32'h0000_0608);
        $display("test latency limits done");
        for (int r = 7; r <= 12; r++) begin
            bus(1'b1, REG_LAT, 32'h0000_0600 | 32'(r));
            cmd(1'b0, 1'b0, 1'b0, 5'(r), 16'h0000, r);
        end
        $display("test read latency done");
        bus(1'b1, REG_LAT, 32'h0000_0608);
        cmd(1'b1, 1'b0, 1'b0, 5'h03, 16'h1234, RET + 1);
        cmd(1'b1, 1'b1, 1'b0, 5'h04, 16'hA53C, RET + 1);
        cmd(1'b1, 1'b1, 1'b0, 5'h05, 16'h0000, RET + 1);
        bus(1'b1, REG_LAT, 32'h0000_0B0C);
        wl <= 4'hB;
        cmd(1'b1, 1'b1, 1'b0, 5'h1F, 16'hF00F, 12);
        bus(1'b1, REG_LAT, 32'h0000_0608);
        wl <= 4'h6;
        $display("test write timing done");
        row(1'b1, 5'h05);
        rd_chk(REG_BANKS, 32'h0000_0020);
        row(1'b1, 5'h06);
        rd_chk(REG_BANKS, 32'h0000_0040);
        rd_chk(REG_STATUS, 32'h0000_0001);
        bus(1'b1, REG_STATUS, 32'h0000_0001);
        rd_chk(REG_STATUS, 32'h0000_0000);
        row(1'b0, 5'h05);
        rd_chk(REG_BANKS, 32'h0000_0000);
        row(1'b1, 5'h09);
        cmd(1'b0, 1'b0, 1'b1, 5'h09, 16'h0000, 8);
        rd_chk(REG_BANKS, 32'h0000_0000);
        row(1'b1, 5'h0C);
        rd_chk(REG_BANKS, 32'h0000_1000);
        go_ap <= 1'b1;
        cmd(1'b0, 1'b0, 1'b0, 5'h0C, 16'h0000, 8);
        rd_chk(REG_BANKS, 32'h0000_0000);
        row(1'b1, 5'h0E);
        rd_chk(REG_BANKS, 32'h0000_4000);
        cmd(1'b1, 1'b0, 1'b0, 5'h0E, 16'h0000, RET + 1);
        rd_chk(REG_BANKS, 32'h0000_0000);
        go_ap <= 1'b0;
        $display("test bank state done");
        report_and_stop();
    end
endmodule // tb
bind pis_core pis_checker #(.RETIRE_INTERVAL(RETIRE_INTERVAL)) u_chk (.*);
